// *** src/lout_mix_pkg.sv ***
// Purpose: shared constants for the line-output mixer control registers
// Assumes: byte-wide register port, 7-bit register addresses, 250 MHz core clock
// Notes: offsets are the printed register numbers
package lout_mix_pkg;

    localparam int unsigned ADDR_W = 7;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned GAIN_W = 7;
    localparam int unsigned LEVEL_W = 4;
    localparam int unsigned NUM_SRC = 8;
    localparam int unsigned NUM_CH = 9;
    localparam int unsigned LEVEL_CH = 8;

    // register offsets
    localparam logic [6:0] RSVD_FIRST_ADDR = 7'h49;
    localparam logic [6:0] RSVD_LAST_ADDR = 7'h4F;
    localparam logic [6:0] L2L_TO_LOUT_ADDR = 7'h50;
    localparam logic [6:0] PREL_TO_LOUT_ADDR = 7'h51;
    localparam logic [6:0] DACL_TO_LOUT_ADDR = 7'h52;
    localparam logic [6:0] L2R_TO_LOUT_ADDR = 7'h53;
    localparam logic [6:0] PRER_TO_LOUT_ADDR = 7'h54;
    localparam logic [6:0] DACR_TO_LOUT_ADDR = 7'h55;
    localparam logic [6:0] LOUT_LEVEL_ADDR = 7'h56;
    localparam logic [6:0] L2L_TO_ROUT_ADDR = 7'h57;
    localparam logic [6:0] PREL_TO_ROUT_ADDR = 7'h58;

    // field positions
    localparam int unsigned ROUTE_BIT = 7;
    localparam int unsigned GAIN_MSB = 6;
    localparam int unsigned LEVEL_MSB = 7;
    localparam int unsigned LEVEL_LSB = 4;
    localparam int unsigned UNMUTE_BIT = 3;
    localparam int unsigned RSVD_BIT = 2;
    localparam int unsigned PEND_BIT = 1;
    localparam int unsigned PWR_BIT = 0;

    // reset values, fixed read values and the level limit
    localparam logic [7:0] SRC_REG_RST = 8'h00;
    localparam logic [3:0] LEVEL_RST = 4'h0;
    localparam logic UNMUTE_RST = 1'b0;
    localparam logic PEND_RST = 1'b1;
    localparam logic PWR_RST = 1'b0;
    localparam logic [7:0] RSVD_READ = 8'h00;
    localparam logic [3:0] LEVEL_MAX = 4'h9;

    // timing
    localparam int unsigned CLK_PERIOD_PS = 4000;
    localparam int unsigned STEP_TIME_NS = 20834;
    localparam int unsigned STEP_CYCLES = (STEP_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned PWRUP_TIME_NS = 10000;
    localparam int unsigned PWRUP_CYCLES = (PWRUP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned CNT_W = 16;

    typedef enum logic [1:0] {PWR_OFF, PWR_RAMP, PWR_ON} pwr_state_t;

endpackage : lout_mix_pkg

// *** src/gain_step_if.sv ***
// Purpose: carrier between the register bank and the gain stepper
// Assumes: one clock domain
// Notes: channel 8 carries the output level code, zero-extended
`timescale 1ns/10ps
interface gain_step_if;
    logic [lout_mix_pkg::NUM_CH-1:0][lout_mix_pkg::GAIN_W-1:0] target;
    logic [lout_mix_pkg::NUM_CH-1:0][lout_mix_pkg::GAIN_W-1:0] applied;
    logic tick;
    logic pending;

    modport ctrl (output target, output tick, input applied, input pending);
    modport stepper (input target, input tick, output applied, output pending);
endinterface : gain_step_if

// *** src/gain_stepper.sv ***
// Purpose: walk each applied gain code one step per tick toward its target
// Assumes: tick is a one-cycle pulse
// Notes: stepping avoids audible zipper noise from large gain jumps
`timescale 1ns/10ps
module gain_stepper (
    input wire logic clk,
    input wire logic rst_n,
    gain_step_if.stepper gs
);
    logic [lout_mix_pkg::NUM_CH-1:0] mismatch;

    genvar ch;
    generate
        for (ch = 0; ch < lout_mix_pkg::NUM_CH; ch++) begin : g_ch
            logic [lout_mix_pkg::GAIN_W-1:0] applied_r;
            logic [lout_mix_pkg::GAIN_W-1:0] applied_nxt;
            logic go_up;
            assign mismatch[ch] = (applied_r != gs.target[ch]);
            assign go_up = (applied_r < gs.target[ch]);
            assign applied_nxt = !(gs.tick && mismatch[ch]) ? applied_r :
                                 go_up ? applied_r + 7'h01 : applied_r - 7'h01;
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    applied_r <= '0;
                end else begin
                    applied_r <= applied_nxt;
                end
            end
            assign gs.applied[ch] = applied_r;
        end
    endgenerate

    assign gs.pending = |mismatch;
endmodule : gain_stepper

// *** src/lout_mix_regs.sv ***
// Purpose: control registers for the left and right line-output mixers
// Assumes: register port strobes are synchronous to CORE_CLK, one access per cycle
// Notes: read data is registered and appears the cycle after REG_RD
// Functional notes
// - Registers 0x49 to 0x4F read all zero and are never meant to be written.
// - Register 0x50 holds a routing enable in bit 7 and a gain code in bits 6-0, both RW, reset zero.
// - Register 0x51 holds a routing enable in bit 7 and a gain code in bits 6-0, both RW, reset zero.
// - Register 0x52 holds a routing enable in bit 7 and a gain code in bits 6-0, both RW, reset zero.
// - Register 0x53 holds a routing enable in bit 7 and a gain code in bits 6-0, both RW, reset zero.
// - Register 0x54 holds a routing enable in bit 7 and a gain code in bits 6-0, both RW, reset zero.
// - Register 0x55 holds a routing enable in bit 7 and a gain code in bits 6-0, both RW, reset zero.
// - Register 0x57 holds a routing enable in bit 7 and a gain code in bits 6-0, both RW, reset zero.
// - Register 0x58 holds a routing enable in bit 7 and a gain code in bits 6-0, both RW, reset zero.
// - Bits 7-4 of register 0x56 set the left output level in 1 dB steps, 0 to 9 dB, reset zero.
// - Bit 3 of register 0x56 is a RW mute control, zero muted and one unmuted.
// - Bit 1 of register 0x56 reads one from reset while programmed gains are still being applied.
// - Bit 0 of register 0x56 reads one only when the left output is fully powered up, reset zero.
// - Bit 2 of register 0x56 reads zero and is not to be written.
`timescale 1ns/10ps
module lout_mix_regs #(
    parameter int unsigned STEP_CYCLES = lout_mix_pkg::STEP_CYCLES
) (
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire logic [lout_mix_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [lout_mix_pkg::DATA_W-1:0] REG_WDATA,
    output logic [lout_mix_pkg::DATA_W-1:0] REG_RDATA,
    input wire logic LEFT_OUT_PWR_REQ,
    output logic [lout_mix_pkg::NUM_SRC-1:0] SRC_ROUTE_EN,
    output logic [lout_mix_pkg::NUM_SRC-1:0][lout_mix_pkg::GAIN_W-1:0] SRC_GAIN,
    output logic [lout_mix_pkg::LEVEL_W-1:0] LEFT_OUT_LEVEL,
    output logic LEFT_OUT_UNMUTE,
    output logic LEFT_OUT_PWR_UP
);

    // source register storage, indexed 0..7 in address order 0x50-0x55, 0x57, 0x58
    logic [lout_mix_pkg::DATA_W-1:0] src_reg_r [lout_mix_pkg::NUM_SRC];
    logic [lout_mix_pkg::LEVEL_W-1:0] level_r;
    logic unmute_r;
    logic pend_r;
    logic [lout_mix_pkg::DATA_W-1:0] rdata_r;
    logic [lout_mix_pkg::DATA_W-1:0] rdata_nxt;
    logic [lout_mix_pkg::CNT_W-1:0] step_cnt_r;
    logic [lout_mix_pkg::CNT_W-1:0] step_cnt_nxt;
    logic [lout_mix_pkg::CNT_W-1:0] pwr_cnt_r;
    logic [lout_mix_pkg::CNT_W-1:0] pwr_cnt_nxt;
    lout_mix_pkg::pwr_state_t pwr_state_r;
    lout_mix_pkg::pwr_state_t pwr_state_nxt;

    localparam logic [lout_mix_pkg::CNT_W-1:0] STEP_LAST = lout_mix_pkg::CNT_W'(STEP_CYCLES - 1);
    localparam logic [lout_mix_pkg::CNT_W-1:0] PWRUP_LAST =
        lout_mix_pkg::CNT_W'(lout_mix_pkg::PWRUP_CYCLES - 1);

    gain_step_if gs ();

    gain_stepper u_stepper (
        .clk(CORE_CLK),
        .rst_n(NRST),
        .gs(gs.stepper)
    );

    // address decode
    logic hit_rsvd;
    logic hit_level;
    logic hit_src;
    logic [2:0] src_idx;
    logic [lout_mix_pkg::NUM_SRC-1:0] src_wr;
    logic level_wr;

    assign hit_rsvd = (REG_ADDR >= lout_mix_pkg::RSVD_FIRST_ADDR) && (REG_ADDR <= lout_mix_pkg::RSVD_LAST_ADDR);
    assign hit_level = (REG_ADDR == lout_mix_pkg::LOUT_LEVEL_ADDR);

    always_comb begin
        hit_src = 1'b1;
        src_idx = 3'h0;
        case (REG_ADDR)
            lout_mix_pkg::L2L_TO_LOUT_ADDR: begin
                src_idx = 3'h0;
            end
            lout_mix_pkg::PREL_TO_LOUT_ADDR: begin
                src_idx = 3'h1;
            end
            lout_mix_pkg::DACL_TO_LOUT_ADDR: begin
                src_idx = 3'h2;
            end
            lout_mix_pkg::L2R_TO_LOUT_ADDR: begin
                src_idx = 3'h3;
            end
            lout_mix_pkg::PRER_TO_LOUT_ADDR: begin
                src_idx = 3'h4;
            end
            lout_mix_pkg::DACR_TO_LOUT_ADDR: begin
                src_idx = 3'h5;
            end
            lout_mix_pkg::L2L_TO_ROUT_ADDR: begin
                src_idx = 3'h6;
            end
            lout_mix_pkg::PREL_TO_ROUT_ADDR: begin
                src_idx = 3'h7;
            end
            default: begin
                hit_src = 1'b0;
            end
        endcase
    end

    assign level_wr = REG_WR && hit_level;

    genvar s;
    generate
        for (s = 0; s < lout_mix_pkg::NUM_SRC; s++) begin : g_src
            assign src_wr[s] = REG_WR && hit_src && (src_idx == 3'(s));
            always_ff @(posedge CORE_CLK) begin
                if (!NRST) begin
                    src_reg_r[s] <= lout_mix_pkg::SRC_REG_RST;
                end else if (src_wr[s]) begin
                    src_reg_r[s] <= REG_WDATA;
                end
            end
            assign SRC_ROUTE_EN[s] = src_reg_r[s][lout_mix_pkg::ROUTE_BIT];
            assign gs.target[s] = src_reg_r[s][lout_mix_pkg::GAIN_MSB:0];
            assign SRC_GAIN[s] = gs.applied[s];
        end
    endgenerate

    // level nibble and mute bit; bits 2..0 of the write are dropped
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            level_r <= lout_mix_pkg::LEVEL_RST;
            unmute_r <= lout_mix_pkg::UNMUTE_RST;
        end else if (level_wr) begin
            level_r <= REG_WDATA[lout_mix_pkg::LEVEL_MSB:lout_mix_pkg::LEVEL_LSB];
            unmute_r <= REG_WDATA[lout_mix_pkg::UNMUTE_BIT];
        end
    end

    // reserved codes are clamped so the analog stage never sees them
    logic [lout_mix_pkg::LEVEL_W-1:0] level_target;
    assign level_target = (level_r > lout_mix_pkg::LEVEL_MAX) ? lout_mix_pkg::LEVEL_MAX : level_r;
    assign gs.target[lout_mix_pkg::LEVEL_CH] = {3'h0, level_target};
    assign LEFT_OUT_LEVEL = gs.applied[lout_mix_pkg::LEVEL_CH][lout_mix_pkg::LEVEL_W-1:0];
    assign LEFT_OUT_UNMUTE = unmute_r;

    // step pacing: one gain step per interval
    logic step_wrap;
    assign step_wrap = (step_cnt_r == STEP_LAST);
    assign step_cnt_nxt = step_wrap ? '0 : step_cnt_r + 16'h0001;
    assign gs.tick = step_wrap;

    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            step_cnt_r <= '0;
        end else begin
            step_cnt_r <= step_cnt_nxt;
        end
    end

    // status follows the stepper, starts at one out of reset
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            pend_r <= lout_mix_pkg::PEND_RST;
        end else begin
            pend_r <= gs.pending;
        end
    end

    always_comb begin
        pwr_state_nxt = pwr_state_r;
        pwr_cnt_nxt = pwr_cnt_r;
        case (pwr_state_r)
            lout_mix_pkg::PWR_OFF: begin
                pwr_cnt_nxt = '0;
                if (LEFT_OUT_PWR_REQ) begin
                    pwr_state_nxt = lout_mix_pkg::PWR_RAMP;
                end
            end
            lout_mix_pkg::PWR_RAMP: begin
                if (!LEFT_OUT_PWR_REQ) begin
                    pwr_state_nxt = lout_mix_pkg::PWR_OFF;
                    pwr_cnt_nxt = '0;
                end else if (pwr_cnt_r == PWRUP_LAST) begin
                    pwr_state_nxt = lout_mix_pkg::PWR_ON;
                end else begin
                    pwr_cnt_nxt = pwr_cnt_r + 16'h0001;
                end
            end
            lout_mix_pkg::PWR_ON: begin
                // power-down is taken as immediate; status drops two cycles after the request falls
                if (!LEFT_OUT_PWR_REQ) begin
                    pwr_state_nxt = lout_mix_pkg::PWR_OFF;
                    pwr_cnt_nxt = '0;
                end
            end
            default: begin
                pwr_state_nxt = lout_mix_pkg::PWR_OFF;
                pwr_cnt_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            pwr_state_r <= lout_mix_pkg::PWR_OFF;
            pwr_cnt_r <= '0;
        end else begin
            pwr_state_r <= pwr_state_nxt;
            pwr_cnt_r <= pwr_cnt_nxt;
        end
    end

    logic pwr_up;
    assign pwr_up = (pwr_state_r == lout_mix_pkg::PWR_ON);

    logic pwr_up_r;
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            pwr_up_r <= lout_mix_pkg::PWR_RST;
        end else begin
            pwr_up_r <= pwr_up;
        end
    end
    assign LEFT_OUT_PWR_UP = pwr_up_r;

    // read path
    logic [lout_mix_pkg::DATA_W-1:0] level_rd;
    logic [lout_mix_pkg::DATA_W-1:0] src_rd;

    assign level_rd = {level_r, unmute_r, 1'b0, pend_r, pwr_up_r};
    assign src_rd = src_reg_r[src_idx];

    // reserved block and unmapped addresses read zero
    assign rdata_nxt = !REG_RD ? rdata_r :
                       hit_src ? src_rd :
                       hit_level ? level_rd :
                       hit_rsvd ? lout_mix_pkg::RSVD_READ : 8'h00;

    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end
    assign REG_RDATA = rdata_r;

endmodule : lout_mix_regs

// *** bench/lout_mix_regs_monitor.sv ***
// Purpose: port-level assertions for the line-output mixer registers
// Assumes: one clock domain, synchronous active-low reset
// Notes: gain spacing is watched on source 0 only to keep the helper logic small
`timescale 1ns/10ps
module lout_mix_regs_monitor #(
    parameter int unsigned STEP_CYCLES = 4
) (
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire logic [6:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA,
    input wire logic LEFT_OUT_PWR_REQ,
    input wire logic [7:0] SRC_ROUTE_EN,
    input wire logic [7:0][6:0] SRC_GAIN,
    input wire logic [3:0] LEFT_OUT_LEVEL,
    input wire logic LEFT_OUT_UNMUTE,
    input wire logic LEFT_OUT_PWR_UP
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);
    logic [15:0] req_cnt_r;
    logic [15:0] gap_r;
    wire logic [2:0] src_idx = (REG_ADDR > 7'h56) ? 3'(REG_ADDR - 7'h51) : 3'(REG_ADDR - 7'h50);
    wire logic src_wr = REG_WR && REG_ADDR >= 7'h50 && REG_ADDR <= 7'h58 && REG_ADDR != 7'h56;
    wire logic lvl_rd = REG_RD && REG_ADDR == 7'h56;
    // saturating counts keep the helpers from wrapping in long runs
    always_ff @(posedge CORE_CLK) begin
        if (!NRST || !LEFT_OUT_PWR_REQ) req_cnt_r <= 16'h0000;
        else if (req_cnt_r != 16'hFFFF) req_cnt_r <= req_cnt_r + 16'h0001;
    end
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) gap_r <= 16'hFFFF;
        else if ($changed(SRC_GAIN[0])) gap_r <= 16'h0000;
        else if (gap_r != 16'hFFFF) gap_r <= gap_r + 16'h0001;
    end
    a_rsvd_read_zero: assert property (REG_RD && REG_ADDR >= 7'h49 && REG_ADDR <= 7'h4F
        |=> REG_RDATA == 8'h00) else $error("reserved register read not zero");
    a_src_route_write: assert property (src_wr
        |=> SRC_ROUTE_EN[$past(src_idx)] == $past(REG_WDATA[7])) else $error("routing enable not written");
    a_unmute_write: assert property (REG_WR && REG_ADDR == 7'h56
        |=> LEFT_OUT_UNMUTE == $past(REG_WDATA[3])) else $error("mute bit not written");
    a_rsvd_bit_zero: assert property (lvl_rd |=> !REG_RDATA[2]) else $error("reserved level bit set");
    a_pwr_bit_read: assert property (lvl_rd
        |=> REG_RDATA[0] == $past(LEFT_OUT_PWR_UP)) else $error("power bit differs from output");
    a_pwr_drop: assert property (!LEFT_OUT_PWR_REQ [*3] |-> !LEFT_OUT_PWR_UP) else $error("power up without request");
    a_pwr_rise_late: assert property ($rose(LEFT_OUT_PWR_UP)
        |-> req_cnt_r >= lout_mix_pkg::PWRUP_CYCLES) else $error("power up too early");
    a_pwr_up_bound: assert property (req_cnt_r == lout_mix_pkg::PWRUP_CYCLES + 8
        |-> LEFT_OUT_PWR_UP) else $error("power up too late");
    a_level_clamp: assert property (LEFT_OUT_LEVEL <= 4'h9) else $error("level above nine");
    a_gain_one_step: assert property ($changed(SRC_GAIN[0]) |-> (gap_r >= STEP_CYCLES - 1) &&
        (SRC_GAIN[0] == $past(SRC_GAIN[0]) + 7'h01 || SRC_GAIN[0] == $past(SRC_GAIN[0]) - 7'h01))
        else $error("gain jumped");
    c_src_write: cover property (src_wr);
    c_pending_read: cover property (lvl_rd ##1 REG_RDATA[1]);
    c_pwr_up: cover property ($rose(LEFT_OUT_PWR_UP));
endmodule : lout_mix_regs_monitor

// *** bench/tb.sv ***
// Purpose: self-checking bench for the line-output mixer registers
// Assumes: inputs change on the falling edge, read data one cycle after the strobe
// Notes: STEP_CYCLES cut to 4 so gain walks finish within a few hundred cycles
`timescale 1ns/10ps
module tb;
    logic clk, nrst, wr, rd, pwr_req, unmute, pwr_up;
    logic [6:0] addr;
    logic [7:0] wdata, rdata, route_en, v;
    logic [7:0][6:0] gain;
    logic [3:0] level;
    int err_count, num_checks, cycles, n;
    lout_mix_regs #(.STEP_CYCLES(4)) lout_mix_regs_i (.CORE_CLK(clk), .NRST(nrst), .REG_ADDR(addr), .REG_WR(wr),
        .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata), .LEFT_OUT_PWR_REQ(pwr_req), .SRC_ROUTE_EN(route_en),
        .SRC_GAIN(gain), .LEFT_OUT_LEVEL(level), .LEFT_OUT_UNMUTE(unmute), .LEFT_OUT_PWR_UP(pwr_up));
    function automatic logic [7:0] pat(input int i);
        return 8'(i * 37 + 5) ^ 8'h80;
    endfunction : pat
    function automatic logic [6:0] src_addr(input int i);
        return (i < 6) ? 7'(8'h50 + i) : 7'(8'h51 + i);
    endfunction : src_addr
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input string what, input logic [6:0] a, input logic [7:0] exp);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk(what, exp, rdata);
    endtask : rd_chk
    // read the level register at the very first edge after release
    task automatic do_reset();
        @(negedge clk);
        nrst = 1'b0;
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        addr = 7'h56;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk("level_rst", 8'h02, rdata);
        for (int a = 8'h49; a <= 8'h58; a++) rd_chk("reset_val", 7'(a), 8'h00);
        chk("route_rst", 8'h00, route_en);
    endtask : do_reset
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            conclude();
        end
    end
    initial begin
        {nrst, wr, rd, pwr_req, addr, wdata} = '0;
        {err_count, num_checks, cycles} = '0;
        do_reset();
        // host never writes the reserved block, so only the unmapped neighbours take junk
        for (n = 8'h48; n <= 8'h59; n += 8'h11) wr_reg(7'(n), 8'hFF);
        for (n = 0; n < 8; n++) wr_reg(src_addr(n), pat(n));
        rd_chk("pending", 7'h56, 8'h02);
        for (n = 8'h48; n <= 8'h59; n++) if (n < 8'h50 || n > 8'h58) rd_chk("reserved", 7'(n), 8'h00);
        // longest walk is 0x74 codes at four cycles a step
        repeat (600) @(negedge clk);
        for (n = 0; n < 8; n++) begin
            v = pat(n);
            rd_chk("src_reg", src_addr(n), v);
            chk("route", {7'h00, v[7]}, {7'h00, route_en[n]});
            chk("gain", {1'b0, v[6:0]}, {1'b0, gain[n]});
        end
        rd_chk("settled", 7'h56, 8'h00);
        // reserved bit 2 kept clear, read-only bits 1..0 written high
        wr_reg(7'h56, 8'h9B);
        rd_chk("level_wr", 7'h56, 8'h9A);
        chk("unmute", 8'h01, {7'h00, unmute});
        repeat (60) @(negedge clk);
        chk("level", 8'h09, {4'h0, level});
        rd_chk("level_rd", 7'h56, 8'h98);
        // host keeps to level codes 0 to 9
        wr_reg(7'h56, 8'h50);
        chk("muted", 8'h00, {7'h00, unmute});
        repeat (40) @(negedge clk);
        chk("level5", 8'h05, {4'h0, level});
        pwr_req = 1'b1;
        n = 0;
        while (pwr_up !== 1'b1 && n < 4000) begin
            @(negedge clk);
            n++;
        end
        chk("pwr_time", 8'h01, {7'h00, n == int'(lout_mix_pkg::PWRUP_CYCLES) + 2});
        rd_chk("pwr_rd", 7'h56, 8'h51);
        pwr_req = 1'b0;
        repeat (3) @(negedge clk);
        chk("pwr_off", 8'h00, {7'h00, pwr_up});
        rd_chk("pwr_rd0", 7'h56, 8'h50);
        do_reset();
        conclude();
    end
endmodule : tb
bind lout_mix_regs lout_mix_regs_monitor #(.STEP_CYCLES(STEP_CYCLES)) lout_mix_regs_monitor_i (
    .CORE_CLK(CORE_CLK), .NRST(NRST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .LEFT_OUT_PWR_REQ(LEFT_OUT_PWR_REQ),
    .SRC_ROUTE_EN(SRC_ROUTE_EN), .SRC_GAIN(SRC_GAIN), .LEFT_OUT_LEVEL(LEFT_OUT_LEVEL),
    .LEFT_OUT_UNMUTE(LEFT_OUT_UNMUTE), .LEFT_OUT_PWR_UP(LEFT_OUT_PWR_UP));
